// *** core/shr_consts.svh ***
// Constants of the sensor host register file: offsets, field positions, codes.
// Assumes inclusion by the package, design and checker files only.
`ifndef SHR_CONSTS_SVH
`define SHR_CONSTS_SVH

`define SHR_ADDR_COMMAND 8'h22
`define SHR_ADDR_TEMP 8'h2e
`define SHR_ADDR_PRESS 8'h30
`define SHR_ADDR_SNAPSHOT 8'h32
`define SHR_ADDR_LIVE 8'h36

`define SHR_CMD_SLEEP 16'h6c32
`define SHR_CMD_RESET 16'hb169
`define SHR_CMD_RESET_VAL 16'h0000

`define SHR_BIT_IDLE 0
`define SHR_BIT_PRESS_UP 3
`define SHR_BIT_TEMP_UP 4
`define SHR_BIT_PRESS_MISSED 14
`define SHR_BIT_TEMP_MISSED 15

`define SHR_EVENT_MASK 16'hcb9e
`define SHR_LEVEL_MASK 16'h3460
`define SHR_EXT_EVENT_MASK 16'h0b86

`endif

// *** core/shr_pkg.sv ***
// Types of the sensor host register file.
// Assumes shr_consts.svh is on the include path.
`include "shr_consts.svh"

package shr_pkg;

   typedef enum logic [1:0] {
      ST_LOAD,
      ST_RUN,
      ST_SLEEP
   } shr_state_t;

   typedef struct packed {
      shr_state_t st;
      logic [15:0] commandWord;
      logic [15:0] tempResult;
      logic [15:0] pressResult;
      logic [15:0] events;
      logic [1:0] snapBits;
      logic crcFail;
      logic softReset;
   } shr_regs_t;

   typedef struct packed {
      logic [7:0] ptr;
      logic aligned;
      logic [7:0] lowByte;
      logic [7:0] hiByte;
      logic [7:0] rdData;
      logic rdValid;
   } shr_lane_t;

endpackage

// *** core/shr_byte_lane.sv ***
// Byte lane between the serial slave and the word registers.
// Assumes the slave gives one start pulse per frame and one strobe per byte.
`timescale 1ns/1ps
`default_nettype none
`include "shr_consts.svh"

module shr_byte_lane (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Byte side
   input wire logic accStart,
   input wire logic [7:0] accAddr,
   input wire logic wrByte,
   input wire logic [7:0] wrData,
   input wire logic rdByte,
   output logic [7:0] rdData,
   output logic rdValid,
   // Word side
   output logic wordWr,
   output logic wordRd,
   output logic [7:0] wordAddr,
   output logic [15:0] wordWrData,
   input wire logic [15:0] wordRdData
);
   import shr_pkg::*;

   shr_lane_t s;
   shr_lane_t next_s;

   always_comb begin
      next_s = s;
      next_s.rdValid = 1'b0;
      wordWr = 1'b0;
      wordRd = 1'b0;
      wordAddr = {s.ptr[7:1], 1'b0};
      wordWrData = {wrData, s.lowByte};
      if (accStart) begin
         next_s.ptr = accAddr;
         next_s.aligned = ~accAddr[0];
      end else if (wrByte) begin
         if (s.aligned) begin
            // Low byte is staged; the high byte commits the whole word
            if (!s.ptr[0]) begin
               next_s.lowByte = wrData;
            end else begin
               wordWr = 1'b1;
            end
         end
         next_s.ptr = 8'(s.ptr + 8'h01);
      end else if (rdByte) begin
         next_s.rdValid = 1'b1;
         if (!s.aligned) begin
            next_s.rdData = 8'h00;
         end else if (!s.ptr[0]) begin
            // Whole word captured at the low byte so the halves stay consistent
            wordRd = 1'b1;
            next_s.rdData = wordRdData[7:0];
            next_s.hiByte = wordRdData[15:8];
         end else begin
            next_s.rdData = s.hiByte;
         end
         next_s.ptr = 8'(s.ptr + 8'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdData = s.rdData;
   assign rdValid = s.rdValid;

endmodule // shr_byte_lane
`default_nettype wire

// *** core/shr_register_file.sv ***
// Host register file: command word, results, live and snapshot status.
// Assumes a serial slave feeding the byte port and a measurement core feeding loads.
`timescale 1ns/1ps
`default_nettype none
`include "shr_consts.svh"

module shr_register_file (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Serial slave byte port
   input wire logic accStart,
   input wire logic [7:0] accAddr,
   input wire logic wrByte,
   input wire logic [7:0] wrData,
   input wire logic rdByte,
   output logic [7:0] rdData,
   output logic rdValid,
   // Measurement core
   input wire logic tempLoad,
   input wire logic [15:0] tempValue,
   input wire logic pressLoad,
   input wire logic [15:0] pressValue,
   input wire logic [15:0] extEvents,
   input wire logic [15:0] levelStatus,
   // Configuration memory
   output logic cfgLoadReq,
   input wire logic cfgLoadDone,
   input wire logic cfgCrcOk,
   // Power control
   output logic sleepMode,
   output logic softReset,
   output logic [15:0] commandWord
);
   import shr_pkg::*;

   shr_regs_t s;
   shr_regs_t next_s;
   logic wordWr;
   logic wordRd;
   logic [7:0] wordAddr;
   logic [15:0] wordWrData;
   logic [15:0] wordRdData;
   logic [15:0] liveWord;
   logic takeTemp;
   logic takePress;
   logic cmdWrite;
   logic liveWrite;
   logic tempRead;
   logic pressRead;
   logic sleepCmd;
   logic resetCmd;

   localparam shr_regs_t RESET_REGS = '{
      st: ST_LOAD,
      commandWord: `SHR_CMD_RESET_VAL,
      tempResult: 16'h0000,
      pressResult: 16'h0000,
      events: 16'h0000,
      snapBits: 2'b00,
      crcFail: 1'b0,
      softReset: 1'b0
   };

   shr_byte_lane lane (
      .clk(clk),
      .reset_n(reset_n),
      .accStart(accStart),
      .accAddr(accAddr),
      .wrByte(wrByte),
      .wrData(wrData),
      .rdByte(rdByte),
      .rdData(rdData),
      .rdValid(rdValid),
      .wordWr(wordWr),
      .wordRd(wordRd),
      .wordAddr(wordAddr),
      .wordWrData(wordWrData),
      .wordRdData(wordRdData)
   );

   // Live status: stored events, hardware levels, idle from the sequencer
   function automatic logic [15:0] live_status(input shr_regs_t r, input logic [15:0] lvl);
      logic [15:0] w;
      w = (r.events & `SHR_EVENT_MASK) | (lvl & `SHR_LEVEL_MASK);
      w[`SHR_BIT_IDLE] = (r.st == ST_RUN);
      return w;
   endfunction

   assign liveWord = live_status(s, levelStatus);

   // Word strobe aimed at one register address
   function automatic logic word_hit(input logic strobe, input logic [7:0] addr,
         input logic [7:0] target);
      return strobe && (addr == target);
   endfunction

   // New result: raise the up flag, and the missed flag when the last one went unread
   function automatic logic [15:0] flag_update(input logic [15:0] ev,
         input logic [15:0] prevEv, input int upBit, input int missedBit);
      logic [15:0] r;
      r = ev;
      r[upBit] = 1'b1;
      if (prevEv[upBit]) begin
         r[missedBit] = 1'b1;
      end
      return r;
   endfunction

   // Word-level strobes, decoded once and shared by the update logic
   assign cmdWrite = word_hit(wordWr, wordAddr, `SHR_ADDR_COMMAND);
   assign liveWrite = word_hit(wordWr, wordAddr, `SHR_ADDR_LIVE);
   assign tempRead = word_hit(wordRd, wordAddr, `SHR_ADDR_TEMP);
   assign pressRead = word_hit(wordRd, wordAddr, `SHR_ADDR_PRESS);
   assign sleepCmd = cmdWrite && (wordWrData == `SHR_CMD_SLEEP);
   // Reset code outranks every other update in its cycle, hardware sets included
   assign resetCmd = cmdWrite && (wordWrData == `SHR_CMD_RESET);

   // Read mux; the command word is write-only and unmapped words read zero
   function automatic logic [15:0] read_word(input logic [7:0] addr, input shr_regs_t r,
         input logic [15:0] live);
      logic [15:0] w;
      case (addr)
         `SHR_ADDR_TEMP: w = r.tempResult;
         `SHR_ADDR_PRESS: w = r.pressResult;
         `SHR_ADDR_SNAPSHOT: begin
            // Live bits, except the two copies taken when the results were read
            w = live;
            w[`SHR_BIT_TEMP_UP] = r.snapBits[1];
            w[`SHR_BIT_PRESS_UP] = r.snapBits[0];
         end
         `SHR_ADDR_LIVE: w = live;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction

   assign wordRdData = read_word(wordAddr, s, liveWord);

   // A failed CRC freezes both results; sleep and loading also block them
   assign takeTemp = tempLoad && (s.st == ST_RUN) && !s.crcFail;
   assign takePress = pressLoad && (s.st == ST_RUN) && !s.crcFail;

   always_comb begin
      next_s = s;
      next_s.softReset = 1'b0;
      // Host side clears are applied first so that hardware sets win
      if (tempRead) begin
         next_s.snapBits[1] = s.events[`SHR_BIT_TEMP_UP];
         next_s.events[`SHR_BIT_TEMP_UP] = 1'b0;
      end
      if (pressRead) begin
         next_s.snapBits[0] = s.events[`SHR_BIT_PRESS_UP];
         next_s.events[`SHR_BIT_PRESS_UP] = 1'b0;
      end
      if (liveWrite) begin
         next_s.events = next_s.events & ~(wordWrData & `SHR_EVENT_MASK);
      end
      // Only two words are writable; other writes drop silently
      if (cmdWrite) begin
         next_s.commandWord = wordWrData;
      end
      if (sleepCmd) begin
         next_s.st = ST_SLEEP;
      end
      if (resetCmd) begin
         // Everything but the pulse returns to its power-up value
         next_s = RESET_REGS;
         next_s.softReset = 1'b1;
      end else begin
         next_s.events = next_s.events | (extEvents & `SHR_EXT_EVENT_MASK);
         // A result taken while its flag is still up marks the earlier one as missed
         if (takeTemp) begin
            next_s.tempResult = tempValue;
            next_s.events = flag_update(next_s.events, s.events, `SHR_BIT_TEMP_UP,
               `SHR_BIT_TEMP_MISSED);
         end
         if (takePress) begin
            next_s.pressResult = pressValue;
            next_s.events = flag_update(next_s.events, s.events, `SHR_BIT_PRESS_UP,
               `SHR_BIT_PRESS_MISSED);
         end
         // Power-up sequence: load configuration memory and latch the CRC verdict
         case (s.st)
            ST_LOAD: begin
               if (cfgLoadDone) begin
                  next_s.crcFail = !cfgCrcOk;
                  next_s.st = ST_RUN;
               end
            end
            ST_RUN: begin
               // Results are taken only in this state
            end
            ST_SLEEP: begin
               // Left only by the reset code or by reset_n
            end
            default: next_s.st = ST_LOAD;
         endcase
      end
   end

   // Results read back as zero until their first measurement has been taken
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= RESET_REGS;
      end else begin
         s <= next_s;
      end
   end

   // Request stays up for the whole load so a slow memory can take its time
   assign cfgLoadReq = (s.st == ST_LOAD);
   // Conditioning stays powered down for as long as this level is high
   assign sleepMode = (s.st == ST_SLEEP);
   // One-cycle pulse asks the rest of the sensor to restart with us
   assign softReset = s.softReset;
   assign commandWord = s.commandWord;

endmodule // shr_register_file
`default_nettype wire

// *** verif/shr_rf_asserts.sv ***
// Port checker for the host register file.
// Assumes it is bound into every shr_register_file instance.
`timescale 1ns/1ps
`default_nettype none
`include "shr_consts.svh"
module shr_rf_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Byte port
   input wire logic accStart,
   input wire logic wrByte,
   input wire logic rdByte,
   input wire logic rdValid,
   // Control
   input wire logic cfgLoadReq,
   input wire logic cfgLoadDone,
   input wire logic sleepMode,
   input wire logic softReset,
   input wire logic [15:0] commandWord
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   rd_answer_a: assert property (rdByte && !accStart && !wrByte |=> rdValid)
      else $error("read byte not answered");
   rd_cause_a: assert property (rdValid |-> $past(rdByte))
      else $error("read answer without request");
   reset_load_a: assert property ($rose(reset_n) |-> cfgLoadReq && !sleepMode)
      else $error("no load after reset");
   cmd_default_a: assert property ($rose(reset_n) |-> commandWord == 16'h0000)
      else $error("command word not zero");
   sleep_exit_a: assert property ($fell(sleepMode) |-> softReset)
      else $error("sleep left without reset code");
   sleep_code_a: assert property ($rose(sleepMode) |-> commandWord == `SHR_CMD_SLEEP)
      else $error("sleep without sleep code");
   reset_pulse_a: assert property (softReset |=> !softReset)
      else $error("reset pulse too long");
   load_done_a: assert property (cfgLoadReq && cfgLoadDone |=> !cfgLoadReq)
      else $error("load not finished");
   cover property (rdValid);
   cover property ($rose(sleepMode));
   cover property (softReset);
endmodule // shr_rf_asserts
bind shr_register_file shr_rf_asserts i_chk (.clk, .reset_n, .accStart, .wrByte, .rdByte,
   .rdValid, .cfgLoadReq, .cfgLoadDone, .sleepMode, .softReset, .commandWord);
`default_nettype wire

// *** verif/shr_cfg_model.sv ***
// Configuration memory model answering load requests.
// Assumes cfgLoadReq stays high until the done pulse is taken.
`timescale 1ns/1ps
`default_nettype none
module shr_cfg_model #(parameter int DELAY = 6) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Load handshake
   input wire logic cfgLoadReq,
   input wire logic crcGood,
   output logic cfgLoadDone,
   output logic cfgCrcOk
);
   int cnt;
   always_ff @(posedge clk) begin
      cfgLoadDone <= 1'b0;
      if (!reset_n || !cfgLoadReq)
         cnt <= 0;
      else if (cnt == DELAY) begin
         cfgLoadDone <= 1'b1;
         cnt <= 0;
      end else
         cnt <= cnt + 1;
   end
   // Verdict is only valid with done, so it shows the wrong level otherwise
   assign cfgCrcOk = cfgLoadDone ? crcGood : !crcGood;
endmodule // shr_cfg_model
`default_nettype wire

// *** verif/sensor_host_register_file_test.sv ***
// Self-checking bench for the host register file.
// Assumes the checker is bound and the config model stands in for memory.
`timescale 1ns/1ps
`default_nettype none
module sensor_host_register_file_test;
   import shr_pkg::*;
   logic clk = 0, reset_n = 0, accStart = 0, wrByte = 0, rdByte = 0, crcGood = 1;
   logic tempLoad = 0, pressLoad = 0, rdValid, cfgLoadReq, cfgLoadDone, cfgCrcOk;
   logic sleepMode, softReset;
   logic [7:0] accAddr = 8'h00, wrData = 8'h00, rdData;
   logic [15:0] tempValue = 16'h0000, pressValue = 16'h0000, extEvents = 16'h0000;
   logic [15:0] tv, pv, commandWord, levelStatus = 16'h0000;
   logic [7:0] expQ[$];
   logic [7:0] adr[3] = '{8'h2f, 8'h40, 8'h22};
   int mismatches = 0, n_checks = 0, nRst = 0;
   shr_register_file i_dut (.clk, .reset_n, .accStart, .accAddr, .wrByte, .wrData, .rdByte,
      .rdData, .rdValid, .tempLoad, .tempValue, .pressLoad, .pressValue, .extEvents,
      .levelStatus, .cfgLoadReq, .cfgLoadDone, .cfgCrcOk, .sleepMode, .softReset,
      .commandWord);
   shr_cfg_model #(.DELAY(6)) i_cfg (.clk, .reset_n, .cfgLoadReq, .crcGood, .cfgLoadDone,
      .cfgCrcOk);
   initial forever #50 clk = ~clk;
   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic s, w, r, input logic [7:0] d);
      @(negedge clk);
      {accStart, wrByte, rdByte} = {s, w, r};
      accAddr = d;
      wrData = d;
      @(negedge clk);
      {accStart, wrByte, rdByte} = 3'b000;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      op(1, 0, 0, a);
      op(0, 1, 0, v[7:0]);
      op(0, 1, 0, v[15:8]);
   endtask
   task automatic rdw(input logic st, input logic [7:0] a, input logic [15:0] v);
      if (st)
         op(1, 0, 0, a);
      expQ.push_back(v[7:0]);
      op(0, 0, 1, 8'h00);
      expQ.push_back(v[15:8]);
      op(0, 0, 1, 8'h00);
   endtask
   task automatic ld(input logic t, input logic [15:0] v);
      @(negedge clk);
      {tempLoad, pressLoad} = {t, !t};
      tempValue = v;
      pressValue = v;
      @(negedge clk);
      {tempLoad, pressLoad} = 2'b00;
   endtask
   task automatic run_wait;
      for (int i = 0; i < 40 && cfgLoadReq !== 1'b0; i++)
         @(negedge clk);
      chk(cfgLoadReq, 1'b0);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Read bytes are matched in order against the notes left by the drivers
   always @(negedge clk) begin
      if (softReset === 1'b1)
         nRst++;
      if (rdValid === 1'b1)
         chk(rdData, expQ.size() ? expQ.pop_front() : 8'hxx);
   end
   initial begin
      #200000;
      mismatches++;
      close_out;
   end
   initial begin
      void'($urandom(32'h27654306));
      tv = $urandom;
      pv = $urandom;
      repeat (10) @(negedge clk);
      reset_n = 1;
      run_wait;
      ld(1, tv);
      ld(0, pv);
      rdw(1, 8'h36, 16'h0019);
      rdw(1, 8'h2e, tv);
      rdw(0, 8'h00, pv);
      rdw(0, 8'h00, 16'h0019);
      rdw(1, 8'h36, 16'h0001);
      $display("test results done");
      ld(1, pv);
      ld(1, tv);
      @(negedge clk) extEvents = 16'h0080;
      @(negedge clk) extEvents = 16'h0000;
      rdw(1, 8'h36, 16'h8091);
      wr16(8'h36, 16'hffff);
      rdw(1, 8'h36, 16'h0001);
      levelStatus = 16'($urandom) & 16'h3460;
      rdw(1, 8'h32, levelStatus | 16'h0019);
      $display("test events done");
      wr16(8'h2e, ~tv);
      wr16(8'h32, 16'hffff);
      rdw(1, 8'h2e, tv);
      foreach (adr[i])
         rdw(1, adr[i], 16'h0000);
      $display("test protection done");
      wr16(8'h22, 16'h6c32);
      @(negedge clk);
      chk(sleepMode, 1'b1);
      chk(commandWord, 16'h6c32);
      crcGood = 0;
      wr16(8'h22, 16'hb169);
      repeat (2) @(negedge clk);
      chk(nRst, 16'h0001);
      chk(cfgLoadReq, 1'b1);
      chk(sleepMode, 1'b0);
      run_wait;
      ld(1, tv);
      rdw(1, 8'h2e, 16'h0000);
      repeat (4) @(negedge clk);
      $display("test commands done");
      close_out;
   end
endmodule // sensor_host_register_file_test
`default_nettype wire
